/* loop_slave_pkg.sv */
// Constants shared by the slave-end burst sequencer.
// What this block does
// - Demod event loads buffer, splits signaling bits
// - Demod event copies receive word to modulator
// - Strobe rise latches inputs, updates outputs
// - Burst starts four 256 kHz bits later
// - Voice bits shift out on clock rises
// - Ninth clock rise swaps the two strobes
// - Codec bits sampled on eight falling edges
// - Receive strobe is inverse of transmit strobe
// - Data clock is crystal divided by 32
// - Sixteenth low phase stretched until next event
// - Power pin weakly driven, actual level used
// - Pin low: no transmit, rest still runs
// - Pin high: answer every master burst
// - No master for 250 us, pin high: free-run frames
// - Free-run bursts every second 125 us period
// - Pin pulled high on burst, low on silence
// - Differential phase on 256 kHz carrier
// - Reversal cusp becomes a 128 kHz half-cycle
// - Burst opens and closes with 256 kHz half-cycle
// - No preamble or start bits sent
// - Ten bits per burst, reply after reception
// - Voice output floats while transmit strobe low
package loop_slave_pkg;
    // Crystal rate emulated from the system clock.
    localparam int unsigned SYS_KHZ = 200000;
    localparam int unsigned XTAL_KHZ = 4096;
    localparam int unsigned CARRIER_KHZ = 256;
    localparam int unsigned ACC_W = 18;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(XTAL_KHZ);
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(SYS_KHZ);
    // Data clock framing in crystal ticks.
    localparam int unsigned DCLK_DIV = 32;
    localparam logic [4:0] DCLK_HALF = 5'(DCLK_DIV / 2);
    localparam logic [3:0] LAST_PERIOD = 4'hF;
    localparam logic [3:0] TE_PERIODS = 4'h8;
    // Burst format.
    localparam int unsigned WORD_BITS = 10;
    localparam int unsigned VOICE_BITS = 8;
    localparam int unsigned BIT_TICKS = XTAL_KHZ / CARRIER_KHZ;
    localparam logic [3:0] HALF_TICKS = 4'(BIT_TICKS / 2);
    localparam int unsigned MOD_DELAY_BITS = 4;
    localparam logic [6:0] MOD_DELAY_TICKS = 7'(MOD_DELAY_BITS * BIT_TICKS);
    localparam logic [4:0] LAST_HALF = 5'(2 * WORD_BITS + 1);
    // Silence and free-run frame times.
    localparam int unsigned SILENCE_US = 250;
    localparam int unsigned FRAME_US = 125;
    localparam logic [10:0] SILENCE_TICKS = 11'(SILENCE_US * XTAL_KHZ / 1000);
    localparam logic [9:0] FRAME_TICKS = 10'(FRAME_US * XTAL_KHZ / 1000);
    localparam int unsigned FIFO_DEPTH = 16;
    typedef enum {MOD_IDLE, MOD_WAIT, MOD_SEND} mod_state_t;
endpackage

/* loop_slave_burst_sequencer.sv */
// Slave-end burst sequencer with its input word FIFO.
`timescale 1ns/10ps
`default_nettype none

// Small flip-flop FIFO with honest full and empty flags.
module burst_word_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // Flags come from the fill count so both sides see the truth.
    assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rd_q];

    // Storage is written only; no reset needed on data.
    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers wrap by index; depth is a power of two.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module loop_slave_burst_sequencer #(
    parameter int unsigned FIFO_WORDS = loop_slave_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic demod_valid_i,
    input wire logic [loop_slave_pkg::WORD_BITS-1:0] demod_word_i,
    output logic demod_ready_o,
    input wire logic rx_voice_i,
    input wire logic signal_in_a_i,
    input wire logic signal_in_b_i,
    output logic data_clock_o,
    output logic transmit_enable_strobe_o,
    output logic receive_enable_strobe_o,
    output logic tx_voice_o,
    output logic tx_voice_oe_n_o,
    output logic signal_out_a_o,
    output logic signal_out_b_o,
    output logic valid_data_flag_o,
    input wire logic power_control_pin_i,
    output logic power_control_pin_o,
    output logic power_control_pin_oe_n_o,
    output logic line_level_o,
    output logic line_drive_o,
    output logic free_run_o
);
    import loop_slave_pkg::*;

    logic [ACC_W-1:0] acc_q;
    logic tick_q;
    logic [1:0] rx_sync_q;
    logic [1:0] sa_sync_q;
    logic [1:0] sb_sync_q;
    logic [1:0] pwr_sync_q;
    logic fifo_valid;
    logic [WORD_BITS-1:0] fifo_word;
    logic master_evt;
    logic active_q;
    logic [3:0] period_q;
    logic [4:0] phase_q;
    logic te_q;
    logic [WORD_BITS-1:0] demod_buf_q;
    logic [VOICE_BITS-1:0] rx_reg_q;
    logic [WORD_BITS-1:0] mod_buf_q;
    logic [VOICE_BITS-1:0] tx_shift_q;
    logic tx_bit_q;
    logic so_a_q;
    logic so_b_q;
    logic vd_q;
    logic [10:0] silence_q;
    logic pwr_drive_q;
    logic [8:0] frame_q;
    logic frame_odd_q;
    mod_state_t mod_q;
    logic [6:0] mod_cnt_q;
    logic [4:0] half_q;
    logic level_q;

    // Crystal tick from a fractional accumulator on the system clock.
    wire [ACC_W-1:0] acc_sum = acc_q + ACC_STEP;
    wire acc_wrap = acc_sum >= ACC_MOD;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_wrap ? acc_sum - ACC_MOD : acc_sum;
            tick_q <= acc_wrap;
        end
    end

    // Pins cross into the clock domain through two flops each.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_sync_q <= '0;
            sa_sync_q <= '0;
            sb_sync_q <= '0;
            pwr_sync_q <= '0;
        end
        else
        begin
            rx_sync_q <= {rx_sync_q[0], rx_voice_i};
            sa_sync_q <= {sa_sync_q[0], signal_in_a_i};
            sb_sync_q <= {sb_sync_q[0], signal_in_b_i};
            pwr_sync_q <= {pwr_sync_q[0], power_control_pin_i};
        end
    end

    wire pin_high = pwr_sync_q[1];

    // Words from the demodulator wait here until a frame may start.
    burst_word_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(demod_valid_i),
        .in_data_i(demod_word_i),
        .in_ready_o(demod_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_word),
        .out_ready_i(master_evt)
    );

    // Frame events: a completed master burst or an internal free-run edge.
    // A new frame is only taken once the previous data clock train ended,
    // so the stretched low phase absorbs the slip to the master.
    wire idle_ok = tick_q && !active_q;
    assign master_evt = idle_ok && fifo_valid;
    wire silent = silence_q == SILENCE_TICKS;
    wire free_run = silent && pin_high;
    wire frame_edge = free_run && tick_q && (frame_q == 9'(FRAME_TICKS - 10'h001));
    wire free_evt = idle_ok && !fifo_valid && frame_edge && frame_odd_q;
    wire frame_evt = master_evt || free_evt;
    wire last_tick = phase_q == 5'(DCLK_DIV - 1);
    // Edges are the ticks at which the clock output itself changes, so the
    // strobes and data move together with the codec's view of the clock.
    wire dclk_rise = tick_q && active_q && last_tick;
    wire dclk_fall = tick_q && active_q && (phase_q == DCLK_HALF - 5'h01);
    wire [VOICE_BITS-1:0] tx_word =
        master_evt ? fifo_word[WORD_BITS-1:2] : demod_buf_q[WORD_BITS-1:2];

    // Data clock: 32 crystal ticks a period, 16 periods, then held low.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            active_q <= 1'b0;
            period_q <= '0;
            phase_q <= '0;
        end
        else if (frame_evt)
        begin
            active_q <= 1'b1;
            period_q <= '0;
            phase_q <= '0;
        end
        else if (tick_q && active_q)
        begin
            phase_q <= phase_q + 5'h01;
            if (last_tick)
            begin
                period_q <= period_q + 4'h1;
                active_q <= period_q != LAST_PERIOD;
            end
        end
    end

    // Transmit strobe rises with the frame and falls on the ninth rise.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            te_q <= 1'b0;
        end
        else if (frame_evt)
        begin
            te_q <= 1'b1;
        end
        else if (dclk_rise && period_q == TE_PERIODS - 4'h1)
        begin
            te_q <= 1'b0;
        end
    end

    // Buffers and signaling outputs change on the frame event.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            demod_buf_q <= '0;
            mod_buf_q <= '0;
            so_a_q <= 1'b0;
            so_b_q <= 1'b0;
            vd_q <= 1'b0;
        end
        else if (frame_evt)
        begin
            if (master_evt)
            begin
                demod_buf_q <= fifo_word;
                so_a_q <= fifo_word[1];
                so_b_q <= fifo_word[0];
            end
            vd_q <= master_evt;
            mod_buf_q <= {rx_reg_q, sa_sync_q[1], sb_sync_q[1]};
        end
    end

    // Voice out on rising edges while the transmit strobe is high.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_shift_q <= '0;
            tx_bit_q <= 1'b0;
        end
        else if (frame_evt)
        begin
            tx_bit_q <= tx_word[VOICE_BITS-1];
            tx_shift_q <= {tx_word[VOICE_BITS-2:0], 1'b0};
        end
        else if (dclk_rise && te_q && period_q < TE_PERIODS - 4'h1)
        begin
            tx_bit_q <= tx_shift_q[VOICE_BITS-1];
            tx_shift_q <= {tx_shift_q[VOICE_BITS-2:0], 1'b0};
        end
    end

    // Codec voice sampled on the falling edges of periods 8 to 15.
    // The codec presents data while the receive strobe is high.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_reg_q <= '0;
        end
        else if (dclk_fall && !te_q)
        begin
            rx_reg_q <= {rx_reg_q[VOICE_BITS-2:0], rx_sync_q[1]};
        end
    end

    // Silence timer and the weak drive level of the power pin.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            silence_q <= '0;
            pwr_drive_q <= 1'b0;
        end
        else if (master_evt)
        begin
            silence_q <= '0;
            pwr_drive_q <= 1'b1;
        end
        else if (tick_q && !silent)
        begin
            silence_q <= silence_q + 11'h001;
            if (silence_q == SILENCE_TICKS - 11'h001)
            begin
                pwr_drive_q <= 1'b0;
            end
        end
    end

    // Free-running 125 us frame; a burst goes out every other period.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            frame_q <= '0;
            frame_odd_q <= 1'b0;
        end
        else if (!free_run)
        begin
            frame_q <= '0;
            frame_odd_q <= 1'b0;
        end
        else if (tick_q)
        begin
            frame_q <= frame_edge ? 9'h000 : frame_q + 9'h001;
            if (frame_edge)
            begin
                frame_odd_q <= !frame_odd_q;
            end
        end
    end

    // Modulator: wait four bit times, then 22 half-cycles of carrier.
    // Half 0 and half 21 are the lone 256 kHz half-cycles at each end;
    // halves 1..20 carry the ten bits, two halves per bit.
    wire [4:0] bit_idx = 5'((half_q - 5'h01) >> 1);
    wire cur_bit = mod_buf_q[4'(WORD_BITS - 1) - bit_idx[3:0]];
    wire boundary = half_q[0] && half_q != LAST_HALF;
    wire skip_flip = boundary && !cur_bit;
    wire half_end = mod_cnt_q == 7'(HALF_TICKS) - 7'h01;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mod_q <= MOD_IDLE;
            mod_cnt_q <= '0;
            half_q <= '0;
            level_q <= 1'b0;
        end
        else
        begin
            case (mod_q)
                MOD_IDLE:
                begin
                    if (frame_evt && pin_high)
                    begin
                        mod_q <= MOD_WAIT;
                        mod_cnt_q <= '0;
                    end
                end
                MOD_WAIT:
                begin
                    if (tick_q)
                    begin
                        mod_cnt_q <= mod_cnt_q + 7'h01;
                        if (mod_cnt_q == MOD_DELAY_TICKS - 7'h01)
                        begin
                            mod_q <= MOD_SEND;
                            mod_cnt_q <= '0;
                            half_q <= '0;
                            level_q <= 1'b1;
                        end
                    end
                end
                MOD_SEND:
                begin
                    if (tick_q)
                    begin
                        mod_cnt_q <= half_end ? 7'h00 : mod_cnt_q + 7'h01;
                        if (half_end && half_q == LAST_HALF)
                        begin
                            mod_q <= MOD_IDLE;
                            level_q <= 1'b0;
                        end
                        else if (half_end)
                        begin
                            half_q <= half_q + 5'h01;
                            level_q <= skip_flip ? level_q : !level_q;
                        end
                    end
                end
                default:
                begin
                    mod_q <= MOD_IDLE;
                end
            endcase
        end
    end

    // Outputs; the receive strobe is derived so it can never disagree.
    assign data_clock_o = active_q && phase_q < DCLK_HALF;
    assign transmit_enable_strobe_o = te_q;
    assign receive_enable_strobe_o = !te_q;
    assign tx_voice_o = tx_bit_q;
    assign tx_voice_oe_n_o = !te_q;
    assign signal_out_a_o = so_a_q;
    assign signal_out_b_o = so_b_q;
    assign valid_data_flag_o = vd_q;
    // Drive is weak on the pad, so it is always enabled; outside wins.
    assign power_control_pin_o = pwr_drive_q;
    assign power_control_pin_oe_n_o = 1'b0;
    assign line_level_o = level_q;
    assign line_drive_o = mod_q == MOD_SEND;
    assign free_run_o = free_run;
endmodule

`default_nettype wire

/* loop_slave_checker.sv */
// Port-level assertions for the slave burst sequencer.
`timescale 1ns/10ps
`default_nettype none
module loop_slave_checker (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic data_clock_o,
    input wire logic transmit_enable_strobe_o,
    input wire logic receive_enable_strobe_o,
    input wire logic tx_voice_oe_n_o,
    input wire logic valid_data_flag_o,
    input wire logic power_control_pin_i,
    input wire logic power_control_pin_o,
    input wire logic line_level_o,
    input wire logic line_drive_o
);
    logic te_q;
    logic low_q;
    logic [2:0] pin_q;
    logic [15:0] since_q;
    logic [15:0] dh_q;
    logic [15:0] th_q;
    // Lengths are counted in system clocks because the crystal tick is not visible here.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            te_q <= 1'b0;
            low_q <= 1'b0;
            pin_q <= 3'h0;
            since_q <= 16'hFFFF;
            dh_q <= 16'h0;
            th_q <= 16'h0;
        end
        else
        begin
            te_q <= transmit_enable_strobe_o;
            pin_q <= {pin_q[1:0], power_control_pin_i};
            dh_q <= data_clock_o ? dh_q + 16'h1 : 16'h0;
            th_q <= transmit_enable_strobe_o ? th_q + 16'h1 : 16'h0;
            // A frame counts as powered down only when the pin sat low and settled.
            if (transmit_enable_strobe_o && !te_q)
            begin
                since_q <= 16'h0;
                low_q <= (pin_q == 3'h0);
            end
            else if (since_q != 16'hFFFF)
                since_q <= since_q + 16'h1;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    AST_RE_INV: assert property (receive_enable_strobe_o == !transmit_enable_strobe_o)
        else $error("receive strobe is not the inverse of transmit strobe");
    AST_OE_FLOAT: assert property (tx_voice_oe_n_o == !transmit_enable_strobe_o)
        else $error("voice output enable does not follow the strobe");
    AST_TE_SWAP: assert property ($fell(transmit_enable_strobe_o) |-> $rose(data_clock_o))
        else $error("strobe fell away from a data clock rise");
    AST_CLK_HALF: assert property ($fell(data_clock_o) |-> dh_q inside {[16'h30B:16'h30F]})
        else $error("data clock high phase is not 16 crystal ticks");
    AST_TE_SPAN: assert property ($fell(transmit_enable_strobe_o)
        |-> th_q inside {[16'h30CF:16'h30D9]}) else $error("strobe did not span 8 clocks");
    AST_BURST_DELAY: assert property ($rose(line_drive_o) && valid_data_flag_o
        |-> since_q inside {[16'hC2E:16'hC3C]}) else $error("burst start is not 4 bits late");
    AST_BURST_OPEN: assert property ($rose(line_drive_o) |-> line_level_o)
        else $error("burst did not open with a high half-cycle");
    AST_PIN_UP: assert property ($rose(transmit_enable_strobe_o) && valid_data_flag_o
        |-> ##[0:2] power_control_pin_o) else $error("power pin drive not raised");
    AST_QUIET_LOW: assert property (low_q |-> !line_drive_o)
        else $error("burst sent while the power pin was low");

    CVR_FRAME: cover property ($rose(transmit_enable_strobe_o));
    CVR_BURST: cover property ($rose(line_drive_o));
    CVR_QUIET: cover property ($rose(low_q));
endmodule

bind loop_slave_burst_sequencer loop_slave_checker port_checks (
    .clk_sys_i, .rst_i, .data_clock_o, .transmit_enable_strobe_o, .receive_enable_strobe_o,
    .tx_voice_oe_n_o, .valid_data_flag_o, .power_control_pin_i, .power_control_pin_o,
    .line_level_o, .line_drive_o);
`default_nettype wire

/* loop_far_side.sv */
// Far-side models: telset codec on the serial pins, master receiver on the line.
`timescale 1ns/10ps
`default_nettype none
module loop_far_side (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic data_clock_i,
    input wire logic receive_enable_strobe_i,
    input wire logic [7:0] codec_word_i,
    input wire logic line_level_i,
    input wire logic line_drive_i,
    output logic rx_voice_o,
    output logic [9:0] burst_word_o,
    output var int burst_count_o
);
    logic ck_q;
    logic [3:0] rise_n;
    logic [3:0] fall_n;
    logic [21:0] half;
    // Codec shifts MSB first on rises in the window; outside it the pin keeps toggling.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ck_q <= 1'b0;
            rise_n <= 4'h0;
            fall_n <= 4'h0;
            rx_voice_o <= 1'b0;
        end
        else
        begin
            ck_q <= data_clock_i;
            rise_n <= !receive_enable_strobe_i ? 4'h0 : rise_n + 4'(data_clock_i && !ck_q);
            fall_n <= !receive_enable_strobe_i ? 4'h0 : fall_n + 4'(!data_clock_i && ck_q);
            if (receive_enable_strobe_i && data_clock_i && !ck_q && rise_n < 4'h8)
                rx_voice_o <= codec_word_i[3'(4'h7 - rise_n)];
            else if (!receive_enable_strobe_i || fall_n >= 4'h8)
                rx_voice_o <= !rx_voice_o;
        end
    end
    // Master samples mid half-cycle; a one flips level into the bit's second half.
    initial
    begin
        burst_count_o = 0;
        burst_word_o = 10'h0;
        forever
        begin
            @(posedge line_drive_i);
            #976.5;
            for (int k = 0; k < 22; k++)
            begin
                half[k] = line_level_i;
                #1953.125;
            end
            for (int j = 0; j < 10; j++)
                burst_word_o[9 - j] = half[2 * j + 2] ^ half[2 * j + 1];
            burst_count_o = burst_count_o + 1;
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// Directed bench for the slave burst sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk, rst, dv, ready, rx, sa, sb, dclk, te, re, txv, oe_n;
    logic soa, sob, vd, pin, drv, drv_oe_n, lvl, ldrv, frun, ext_en, ext_val;
    logic [9:0] dw;
    logic [9:0] bw;
    int bn;
    int mismatches;
    int cmp_count;
    localparam logic [9:0] W1 = 10'h2D1;
    localparam logic [9:0] W2 = 10'h1A2;
    localparam logic [7:0] CODEC = 8'h5C;
    // An outside driver overpowers the weak one; an undriven pin is pulled low.
    assign pin = ext_en ? ext_val : (!drv_oe_n ? drv : 1'b0);
    // Short queue: a 16-word refusal would need sixteen 125 us frames to drain.
    loop_slave_burst_sequencer #(.FIFO_WORDS(2)) uut (
        .clk_sys_i(clk), .rst_i(rst), .demod_valid_i(dv), .demod_word_i(dw),
        .demod_ready_o(ready), .rx_voice_i(rx), .signal_in_a_i(sa), .signal_in_b_i(sb),
        .data_clock_o(dclk), .transmit_enable_strobe_o(te), .receive_enable_strobe_o(re),
        .tx_voice_o(txv), .tx_voice_oe_n_o(oe_n), .signal_out_a_o(soa), .signal_out_b_o(sob),
        .valid_data_flag_o(vd), .power_control_pin_i(pin), .power_control_pin_o(drv),
        .power_control_pin_oe_n_o(drv_oe_n), .line_level_o(lvl), .line_drive_o(ldrv),
        .free_run_o(frun));
    loop_far_side far_end (
        .clk_i(clk), .rst_i(rst), .data_clock_i(dclk), .receive_enable_strobe_i(re),
        .codec_word_i(CODEC), .line_level_i(lvl), .line_drive_i(ldrv), .rx_voice_o(rx),
        .burst_word_o(bw), .burst_count_o(bn));
    // System clock at 200 MHz.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bounded wait, polled at falling clock edges, for a level on the strobe (0), data clock (1) or pin drive (2).
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        int n = 0;
        while ((sel == 0 ? te : sel == 1 ? dclk : drv) !== lvl)
        begin
            @(negedge clk);
            n++;
            if (n > lim)
            begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask
    // One codec frame: outputs at the strobe rise, voice bits sampled mid-period.
    task automatic t_frame(input logic [9:0] w);
        logic [7:0] got;
        wait_for(0, 1'b1, 30000);
        chk({7'h0, soa, sob, vd}, {7'h0, w[1:0], 1'b1});
        for (int i = 0; i < 8; i++)
        begin
            wait_for(1, 1'b0, 1000);
            got[7 - i] = txv;
            wait_for(1, 1'b1, 1000);
        end
        chk({7'h0, te, re, oe_n}, 10'h3);
        chk({2'h0, got}, {2'h0, w[9:2]});
    endtask
    // Reset state, then two back-to-back pushes fill the queue before the first tick.
    task automatic t_reset_fill;
        chk({te, re, oe_n, ready, dclk, ldrv, drv, vd, soa, sob}, 10'h1C0);
        rst = 1'b0;
        @(negedge clk);
        dv = 1'b1;
        dw = W1;
        @(negedge clk);
        dw = W2;
        @(negedge clk);
        chk(10'(ready), 10'h0);
        dv = 1'b0;
    endtask
    // Pin held low from outside: the codec side runs, the line stays quiet.
    task automatic t_quiet_frame;
        t_frame(W1);
        chk({8'h0, pin, drv}, 10'h1);
        chk(10'(bn), 10'h0);
        ext_en = 1'b0;
    endtask
    // Pin high: the reply carries last window's codec word and the new A and B.
    task automatic t_answer_frame;
        sa = 1'b1;
        sb = 1'b0;
        t_frame(W2);
        chk(10'(bn), 10'h1);
        chk(bw, {CODEC, 2'b10});
    endtask
    // Silence drops the weak drive; an outside high then starts free-running.
    task automatic t_silence;
        chk(10'(drv), 10'h1);
        wait_for(2, 1'b0, 45000);
        // The synchronised pin lags the drive by two clocks.
        repeat (3) @(negedge clk);
        chk({7'h0, pin, frun, ldrv}, 10'h0);
        ext_en = 1'b1;
        ext_val = 1'b1;
        repeat (4) @(negedge clk);
        chk(10'(frun), 10'h1);
    endtask
    // Main sequence.
    initial
    begin
        rst = 1'b1;
        dv = 1'b0;
        dw = 10'h0;
        sa = 1'b0;
        sb = 1'b1;
        ext_en = 1'b1;
        ext_val = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        repeat (3) @(negedge clk);
        t_reset_fill();
        t_quiet_frame();
        t_answer_frame();
        t_silence();
        report_and_stop();
    end
endmodule
`default_nettype wire
